/* hdl/pwg_pkg.sv */
/*
  Package for the write guard and non-volatile store block: command codes,
  the bus_feature_report byte, protect levels, reset values, timing and carriers.
  Assumes a PMBus front end that has already framed each transaction.
*/
// Function
// - Level 00h accepts every supported write
// - Level 20h allows five listed commands only
// - Level 40h allows lock, OPERATION, store only
// - Level 80h allows lock and store only
// - Other lock values flagged as unsupported data
// - Reads always answered, whatever the lock level
// - Store copies backed operating items to store
// - Store never blocked; commands ignored while busy
// - Restore halts regulation, then loads backed items
// - Restore then overrides selected items from straps
// - Bus_feature_report is a one byte read only
// - Bus_feature_report bit 7 reads one
// - Bus_feature_report bits 6:5 read 10b
// - Bus_feature_report bit 4 reads one
// - Bus_feature_report bits 3:0 read zero
// - Bus_feature_report write flagged as unsupported data
// - Phase FFh addresses all phases together
package pwg_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF    = 8'h02;
  localparam logic [7:0] CMD_LOCK      = 8'h10;
  localparam logic [7:0] CMD_SAVE      = 8'h15;
  localparam logic [7:0] CMD_LOAD      = 8'h16;
  localparam logic [7:0] CMD_FEATURE   = 8'h19;
  localparam logic [7:0] CMD_VOUT      = 8'h21;

  // ----------------------------------------------------------------
  // Lock levels, phase and bus_feature_report fields
  // ----------------------------------------------------------------
  localparam logic [7:0] LOCK_OPEN  = 8'h00;
  localparam logic [7:0] LOCK_VOUT  = 8'h20;
  localparam logic [7:0] LOCK_OPER  = 8'h40;
  localparam logic [7:0] LOCK_ALL   = 8'h80;
  localparam logic [7:0] PHASE_ALL  = 8'hFF;
  localparam logic [0:0] CAP_PEC    = 1'h1;
  localparam logic [1:0] CAP_SPEED  = 2'h2;
  localparam logic [0:0] CAP_ALERT  = 1'h1;
  localparam logic [0:0] CAP_FORMAT = 1'h0;
  localparam logic [0:0] CAP_AVS    = 1'h0;
  localparam logic [1:0] CAP_RSVD   = 2'h0;
  localparam logic [7:0] CAP_VALUE  = {CAP_PEC, CAP_SPEED, CAP_ALERT,
                                       CAP_FORMAT, CAP_AVS, CAP_RSVD};

  // ----------------------------------------------------------------
  // Operating item slots, reset values, timing
  // ----------------------------------------------------------------
  localparam int         ITEM_LOCK   = 0;
  localparam int         ITEM_OPER   = 1;
  localparam int         ITEM_ONOFF  = 2;
  localparam int         ITEM_VOUT   = 3;
  localparam logic [31:0] ITEM_RESET = 32'h00_00_00_00;
  localparam logic [3:0]  BACKED_RST = 4'hF;
  localparam int         CLK_HZ      = 40_000_000;
  localparam int         NVM_WAIT_MS = 100;
  localparam int         NVM_WAIT_CYC = NVM_WAIT_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;    // One framed transaction
    logic       write;    // 1 write or send byte, 0 read
    logic [7:0] code;     // Command code
    logic [7:0] data;     // Write data byte
  } pwg_cmd_s;

  typedef struct packed {
    logic       valid;       // Answer for an owned command
    logic [7:0] data;        // Read data
    logic       cmd_fault;   // Unsupported or refused command
    logic       data_fault;  // Unsupported data
  } pwg_rsp_s;

endpackage

/* hdl/pwg_guard.sv */
/*
  Write guard, store, restore and bus_feature_report command handler.
  Assumes the PMBus front end presents one framed transaction per pulse,
  holds clock stretch while busy is high, and keeps status and alert logic.
*/
`timescale 1ns/1ps
module pwg_guard
  import pwg_pkg::*;
#(
  parameter int          ITEMS     = 4,             // Operating items held here
  parameter logic [3:0]  BACKED    = BACKED_RST,    // Items with a store slot
  parameter logic [31:0] RST_ITEMS = ITEM_RESET,    // Power-up item values
  parameter int          HOLD_CYC  = NVM_WAIT_CYC   // Busy time after a store
) (
  input  wire logic              sys_clk,     // 40 MHz clock
  input  wire logic              reset,       // Synchronous, active high
  input  wire pwg_cmd_s          cmd,         // Framed command
  input  wire logic [7:0]        phase,       // Current phase select
  input  wire logic [ITEMS-1:0]  strap_value_reload_select, // Straps win
  input  wire logic [ITEMS*8-1:0] strap_vals, // Last pin-detected values
  output pwg_rsp_s               rsp,         // Answer, one cycle later
  output logic                   fwd_valid,   // Pass-through to other cmds
  output logic                   busy,        // Stretch or ignore request
  output logic                   reg_halt,    // Regulation must stop
  output logic                   all_phases,  // Phase addresses all
  output logic [7:0]             lock_level   // Current protect level
);

  // ----------------------------------------------------------------
  // Types and storage
  // ----------------------------------------------------------------
  localparam int IW = (ITEMS > 1) ? $clog2(ITEMS) : 1;

  typedef enum logic [2:0] {
    PWG_IDLE, PWG_SAVE, PWG_HOLD, PWG_LOAD, PWG_STRAP
  } pwg_state_e;

  pwg_state_e     state_r, state_nxt;           // Sequencer
  logic [7:0]     op_r  [ITEMS];                // Operating memory
  logic [7:0]     nvm_r [ITEMS];                // User store image
  logic [IW-1:0]  idx_r, idx_nxt;               // Copy index
  logic [31:0]    hold_r, hold_nxt;             // Post-store busy count
  pwg_rsp_s       rsp_r, rsp_nxt;               // Registered answer
  logic           halt_r, halt_nxt;             // Regulation halt level

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // True for the codes that own an operating item here
  function automatic logic item_hit(input logic [7:0] code);
    item_hit = (code == CMD_LOCK) || (code == CMD_OPERATION) ||
               (code == CMD_ON_OFF) || (code == CMD_VOUT);
  endfunction

  // Maps a command code to its operating item slot
  function automatic logic [IW-1:0] item_of(input logic [7:0] code);
    case (code)
      CMD_OPERATION: item_of = IW'(ITEM_OPER);
      CMD_ON_OFF:    item_of = IW'(ITEM_ONOFF);
      CMD_VOUT:      item_of = IW'(ITEM_VOUT);
      default:       item_of = IW'(ITEM_LOCK);
    endcase
  endfunction

  // Whether the protect level lets a write reach this code
  function automatic logic lock_allows(input logic [7:0] lvl,
                                       input logic [7:0] code);
    case (lvl)
      LOCK_OPEN: lock_allows = 1'b1;
      LOCK_VOUT: lock_allows = (code == CMD_LOCK) || (code == CMD_OPERATION) ||
                               (code == CMD_ON_OFF) || (code == CMD_SAVE) ||
                               (code == CMD_VOUT);
      LOCK_OPER: lock_allows = (code == CMD_LOCK) || (code == CMD_OPERATION) ||
                               (code == CMD_SAVE);
      LOCK_ALL:  lock_allows = (code == CMD_LOCK) || (code == CMD_SAVE);
      // Lock writes never store undefined levels, but a strap reload of the lock item can; only store and reads pass them
      default:   lock_allows = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Named decode wires
  // ----------------------------------------------------------------
  // All but idle and last_idx look at the command in the cycle in which it is offered
  wire        idle     = (state_r == PWG_IDLE);
  wire        take     = cmd.valid && idle;          // Ignored while busy
  wire        is_item  = item_hit(cmd.code);
  wire        is_lock  = (cmd.code == CMD_LOCK);
  wire        is_save  = (cmd.code == CMD_SAVE);
  wire        is_load  = (cmd.code == CMD_LOAD);
  wire        is_feat  = (cmd.code == CMD_FEATURE);
  wire        owned    = is_item || is_save || is_load || is_feat;
  wire        allowed  = lock_allows(op_r[ITEM_LOCK], cmd.code);
  wire [IW-1:0] slot   = item_of(cmd.code);
  wire        lvl_ok   = (cmd.data == LOCK_OPEN) || (cmd.data == LOCK_VOUT) ||
                         (cmd.data == LOCK_OPER) || (cmd.data == LOCK_ALL);
  wire        wr_take  = take && cmd.write;
  wire        rd_take  = take && !cmd.write;
  wire        item_wr  = wr_take && is_item && allowed && (!is_lock || lvl_ok);
  wire        save_go  = wr_take && is_save;         // Always allowed
  wire        load_go  = wr_take && is_load && allowed;
  wire        last_idx = (idx_r == IW'(ITEMS - 1));

  assign all_phases = (phase == PHASE_ALL);
  // Busy doubles as the stretch request; nothing is buffered meanwhile
  assign busy       = !idle;
  assign fwd_valid  = take && !owned && (!cmd.write || allowed);
  assign rsp        = rsp_r;
  assign reg_halt   = halt_r;
  assign lock_level = op_r[ITEM_LOCK];

  // ----------------------------------------------------------------
  // Answer for owned commands
  // ----------------------------------------------------------------
  // Faults are raised here and the status block sets the flags
  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.valid = take && owned;
    if (rd_take) begin
      if (is_feat) begin
        rsp_nxt.data = CAP_VALUE;
      end else if (is_item) begin
        rsp_nxt.data = op_r[slot];
      end else if (is_save || is_load) begin
        rsp_nxt.cmd_fault = 1'b1;                    // Send-byte only commands
      end
    end else if (wr_take) begin
      if (is_feat) begin
        rsp_nxt.data_fault = 1'b1;
      end else if ((is_item || is_load) && !allowed) begin
        rsp_nxt.cmd_fault = 1'b1;
      end else if (is_lock && !lvl_ok) begin
        rsp_nxt.data_fault = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Store and restore sequencer
  // ----------------------------------------------------------------
  // One item per cycle keeps the copy path to a single byte mux
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    hold_nxt  = hold_r;
    halt_nxt  = halt_r;
    case (state_r)
      PWG_IDLE: begin
        idx_nxt = '0;
        if (save_go) begin
          state_nxt = PWG_SAVE;
        end else if (load_go) begin
          state_nxt = PWG_LOAD;
          halt_nxt  = 1'b1;
        end
      end
      PWG_SAVE: begin
        // Items without a store slot are skipped by the backed mask
        idx_nxt = idx_r + 1'b1;
        if (last_idx) begin
          state_nxt = PWG_HOLD;
          hold_nxt  = 32'(HOLD_CYC);
        end
      end
      PWG_HOLD: begin
        // Models the long write time; the bus is stretched meanwhile
        hold_nxt = hold_r - 32'h1;
        if (hold_r <= 32'h1) begin
          state_nxt = PWG_IDLE;
        end
      end
      PWG_LOAD: begin
        // Regulation stays halted while items change underneath it
        idx_nxt = idx_r + 1'b1;
        if (last_idx) begin
          state_nxt = PWG_STRAP;
        end
      end
      PWG_STRAP: begin
        // Pins win over the stored image, so the override comes last
        state_nxt = PWG_IDLE;
        halt_nxt  = 1'b0;
      end
      default: begin
        state_nxt = PWG_IDLE;
      end
    endcase
  end

  // Sequencer state and answer registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= PWG_IDLE;
      idx_r   <= '0;
      hold_r  <= 32'h0;
      halt_r  <= 1'b0;
      rsp_r   <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      hold_r  <= hold_nxt;
      halt_r  <= halt_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Operating memory and user store image
  // ----------------------------------------------------------------
  // Refused writes never reach here, so the old value stays
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < ITEMS; i++) begin
        op_r[i]  <= RST_ITEMS[i*8 +: 8];
        nvm_r[i] <= RST_ITEMS[i*8 +: 8];
      end
    end else begin
      if (item_wr) begin
        op_r[slot] <= cmd.data;
      end
      if (state_r == PWG_SAVE && BACKED[idx_r]) begin
        nvm_r[idx_r] <= op_r[idx_r];
      end
      if (state_r == PWG_LOAD && BACKED[idx_r]) begin
        op_r[idx_r] <= nvm_r[idx_r];
      end
      if (state_r == PWG_STRAP) begin
        for (int i = 0; i < ITEMS; i++) begin
          if (strap_value_reload_select[i]) begin
            op_r[i] <= strap_vals[i*8 +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_feature_value: assert property (@(posedge sys_clk) disable iff (reset)
    (rd_take && is_feat) |=> (rsp.valid && rsp.data == 8'hD0 && !rsp.cmd_fault))
    else $error("bus_feature_report byte wrong");

  chk_feature_write: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_take && is_feat) |=> (rsp.data_fault && $stable(lock_level)))
    else $error("bus_feature_report write not flagged");

  chk_bad_level: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_take && is_lock && !lvl_ok) |=> (rsp.data_fault && $stable(lock_level)))
    else $error("bad level accepted");

  chk_locked_write: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_take && lock_level == 8'h80 && cmd.code == 8'h01)
      |=> (rsp.cmd_fault && $stable(op_r[ITEM_OPER])))
    else $error("write passed level 80h");

  chk_open_write: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_take && lock_level == 8'h00 && cmd.code == 8'h21)
      |=> (op_r[ITEM_VOUT] == $past(cmd.data) && !rsp.cmd_fault))
    else $error("open write lost");

  chk_read_locked: assert property (@(posedge sys_clk) disable iff (reset)
    (rd_take && is_item) |=> (rsp.valid && !rsp.cmd_fault && rsp.data == $past(op_r[slot])))
    else $error("read refused");

  chk_load_halt: assert property (@(posedge sys_clk) disable iff (reset)
    load_go |=> reg_halt [*4] ##1 (reg_halt && state_r == PWG_STRAP))
    else $error("restore without halt");

  chk_save_busy: assert property (@(posedge sys_clk) disable iff (reset)
    save_go |=> (busy && !reg_halt) [*4] ##1 (state_r == PWG_HOLD))
    else $error("store sequence wrong");

  // Level checks use literal codes, so a slip in a package constant
  // still shows up here instead of agreeing with itself
  chk_vout_level: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_take && lock_level == 8'h20 && cmd.code == 8'h21)
      |=> (op_r[ITEM_VOUT] == $past(cmd.data) && !rsp.cmd_fault))
    else $error("write refused at level 20h");

  chk_oper_level: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_take && lock_level == 8'h40 && cmd.code == 8'h02)
      |=> (rsp.cmd_fault && $stable(op_r[ITEM_ONOFF])))
    else $error("write passed level 40h");

  chk_busy_ignore: assert property (@(posedge sys_clk) disable iff (reset)
    (cmd.valid && busy) |-> (!fwd_valid ##1 !rsp.valid))
    else $error("command taken while busy");

  chk_save_image: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == PWG_HOLD && BACKED[ITEM_VOUT]) |-> (nvm_r[ITEM_VOUT] == op_r[ITEM_VOUT]))
    else $error("store image differs");

  chk_strap_reload: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == PWG_STRAP && strap_value_reload_select[ITEM_VOUT])
      |=> (op_r[ITEM_VOUT] == $past(strap_vals[ITEM_VOUT*8 +: 8])))
    else $error("strap value not reloaded");

  chk_load_end: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == PWG_STRAP) |=> (!reg_halt && !busy))
    else $error("restore did not release");

  chk_refused_load: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_take && is_load && lock_level != 8'h00) |=> (rsp.cmd_fault && !busy))
    else $error("restore ran under lock");

endmodule

/* test/pwg_host.sv */
/*
  Host model for the write guard block: issues framed commands.
  Assumes one clock shared with the block and a bench that calls issue.
*/
`timescale 1ns/1ps
module pwg_host
  import pwg_pkg::*;
(
  input  wire logic       sys_clk,   // Shared clock
  input  wire logic       busy,      // Block is stretching
  input  wire logic       fwd_valid, // Pass-through pulse
  output pwg_cmd_s        cmd,       // Framed command
  output logic [7:0]      phase      // Phase select
);
  initial begin
    cmd = '0;
    phase = PHASE_ALL;
  end

  // -----------------------------------------------
  // Phase and command tasks
  // -----------------------------------------------
  task automatic set_phase(input logic [7:0] p);
    @(posedge sys_clk);
    phase <= p;
  endtask

  // Idle bus shows inverted fields, never a stale copy
  task automatic issue(input logic w, input logic [7:0] c, input logic [7:0] d,
                       input bit rude, output logic fwd, output int stall);
    stall = 0;
    if ((c == CMD_SAVE || c == CMD_LOAD) && phase !== PHASE_ALL) begin
      set_phase(PHASE_ALL);
    end
    while (!rude && stall < 200) begin
      @(negedge sys_clk);
      if (busy === 1'b0) break;
      stall++;
    end
    @(posedge sys_clk);
    cmd <= '{valid: 1'b1, write: w, code: c, data: d};
    @(negedge sys_clk);
    fwd = fwd_valid;
    @(posedge sys_clk);
    cmd <= '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
  endtask
endmodule

/* test/testbench.sv */
/*
  Self-checking bench for the write guard block.
  Assumes the host model drives commands; a monitor compares answers.
*/
`timescale 1ns/1ps
module testbench;
  import pwg_pkg::*;
  typedef struct packed {
    logic [7:0] data; // Expected read byte
    logic       cf;   // Expected command fault
    logic       df;   // Expected data fault
  } pwg_exp_s;
  localparam int HOLD = 4; // Shortened hold after a store
  logic        sys_clk, reset;              // Clock and reset
  pwg_cmd_s    cmd;                         // From host
  logic [7:0]  phase, lock_level;           // Phase and level
  logic [3:0]  strap_value_reload_select;   // Strap choice
  logic [31:0] strap_vals, seed;            // Straps, random state
  pwg_rsp_s    rsp;                         // Answer
  logic        fwd_valid, busy, reg_halt, all_phases, fwd; // Status
  int          err_total, checks, stall;    // Counters
  pwg_exp_s    expq[$];                     // Expected answers
  logic [7:0]  item[4], img[4], lv[4], cd[4]; // Model and tables

  pwg_guard #(.HOLD_CYC(HOLD)) pwg_guard_i (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
    .phase(phase), .strap_value_reload_select(strap_value_reload_select),
    .strap_vals(strap_vals), .rsp(rsp), .fwd_valid(fwd_valid), .busy(busy),
    .reg_halt(reg_halt), .all_phases(all_phases), .lock_level(lock_level));
  pwg_host pwg_host_i (.sys_clk(sys_clk), .busy(busy), .fwd_valid(fwd_valid),
    .cmd(cmd), .phase(phase));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // -----------------------------------------------
  // Helpers
  // -----------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic int slot(input logic [7:0] c);
    for (int i = 0; i < 4; i++) begin
      if (c == (i == 0 ? CMD_LOCK : cd[i-1])) return i;
    end
    return -1;
  endfunction

  // Store is always open; restore only at level 00h
  function automatic bit allowed(input logic [7:0] c);
    if (c == CMD_LOCK || c == CMD_SAVE || item[0] == LOCK_OPEN) return 1'b1;
    if (c == CMD_OPERATION) return item[0] != LOCK_ALL;
    return (c == CMD_ON_OFF || c == CMD_VOUT) && item[0] == LOCK_VOUT;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Mode 0 normal, 1 sent while busy, 2 skip busy timing
  task automatic op(input logic w, input logic [7:0] c, input logic [7:0] d, input int mode);
    int s, n, h;
    bit own, nv;
    pwg_exp_s e;
    s = slot(c);
    e = '0;
    own = s >= 0 || c inside {CMD_SAVE, CMD_LOAD, CMD_FEATURE};
    nv = !(d inside {LOCK_OPEN, LOCK_VOUT, LOCK_OPER, LOCK_ALL});
    if (mode != 1) begin
      if (!w && s >= 0) e.data = item[s];
      else if (!w && c == CMD_FEATURE) e.data = {1'h1, 2'h2, 1'h1, 1'h0, 1'h0, 2'h0};
      else if (!w) e.cf = c inside {CMD_SAVE, CMD_LOAD};
      else if (c == CMD_FEATURE) e.df = 1'b1;
      else if (own && !allowed(c)) e.cf = 1'b1;
      else if (c == CMD_LOCK && nv) e.df = 1'b1;
      else if (s >= 0) item[s] = d;
      else if (c == CMD_SAVE) img = item;
      else if (c == CMD_LOAD) begin
        for (int i = 0; i < 4; i++) begin
          item[i] = strap_value_reload_select[i] ? strap_vals[8*i+:8] : img[i];
        end
      end
      if (own) expq.push_back(e);
    end
    pwg_host_i.issue(w, c, d, mode == 1, fwd, stall);
    chk({7'h0, fwd}, {7'h0, mode != 1 && !own && (!w || lv[0] == item[0])}, "forward");
    if (stall >= 200) begin
      err_total++;
      close_out();
    end
    if (mode == 0 && w && !e.cf && c inside {CMD_SAVE, CMD_LOAD}) begin
      n = 0;
      h = 0;
      do begin
        @(negedge sys_clk);
        n += int'(busy === 1'b1);
        h += int'(reg_halt === 1'b1);
      end while (busy === 1'b1 && n < 100);
      chk(8'(n), 8'(c == CMD_SAVE ? 4 + HOLD : 5), "busy span");
      chk(8'(h), 8'(c == CMD_SAVE ? 0 : 5), "halt span");
    end
    @(negedge sys_clk);
    chk(lock_level, item[0], "level");
  endtask

  // -----------------------------------------------
  // Answer monitor
  // -----------------------------------------------
  always @(negedge sys_clk) begin
    if (reset === 1'b0 && rsp.valid === 1'b1) begin
      if (expq.size() == 0) chk(8'h01, 8'h00, "extra answer");
      else begin
        chk(rsp.data, expq[0].data, "data");
        chk({6'h0, rsp.cmd_fault, rsp.data_fault}, {6'h0, expq[0].cf, expq[0].df}, "fault");
        void'(expq.pop_front());
      end
    end
  end

  // -----------------------------------------------
  // Main sequence
  // -----------------------------------------------
  initial begin
    err_total = 0;
    checks = 0;
    seed = 32'h1792;
    reset = 1'b1;
    strap_value_reload_select = 4'h0;
    strap_vals = 32'h0;
    lv = '{LOCK_OPEN, LOCK_VOUT, LOCK_OPER, LOCK_ALL};
    cd = '{CMD_OPERATION, CMD_ON_OFF, CMD_VOUT, 8'h30};
    item = '{default: 8'h00};
    img = '{default: 8'h00};
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk({6'h0, busy, reg_halt}, 8'h00, "idle after reset");
    pwg_host_i.set_phase(8'h00);
    @(negedge sys_clk);
    chk({7'h0, all_phases}, 8'h00, "one phase");
    pwg_host_i.set_phase(PHASE_ALL);
    @(negedge sys_clk);
    chk({7'h0, all_phases}, 8'h01, "all phases");
    op(1'b0, CMD_FEATURE, 8'h00, 0);
    op(1'b1, CMD_FEATURE, rnd(), 0);
    op(1'b0, CMD_SAVE, 8'h00, 0);
    foreach (lv[k]) begin
      op(1'b1, CMD_LOCK, lv[k], 0);
      foreach (cd[j]) begin
        op(1'b1, cd[j], rnd(), 0);
        op(1'b0, cd[j], 8'h00, 0);
      end
      op(1'b1, CMD_LOCK, rnd() | 8'h01, 0);
      op(1'b1, CMD_LOAD, 8'h00, 0);
    end
    op(1'b1, CMD_SAVE, 8'h00, 0);
    op(1'b1, CMD_LOCK, LOCK_OPEN, 0);
    op(1'b1, CMD_SAVE, 8'h00, 2);
    op(1'b1, CMD_OPERATION, rnd(), 1);
    op(1'b1, CMD_SAVE, 8'h00, 0);
    for (int j = 0; j < 3; j++) op(1'b1, cd[j], rnd(), 0);
    @(posedge sys_clk);
    strap_value_reload_select <= (4'(rnd() >> 4) & 4'hE) | 4'h8;
    strap_vals <= {rnd(), rnd(), rnd(), rnd()};
    @(negedge sys_clk);
    op(1'b1, CMD_LOAD, 8'h00, 0);
    for (int j = 0; j < 3; j++) op(1'b0, cd[j], 8'h00, 0);
    op(1'b0, CMD_LOCK, 8'h00, 0);
    repeat (3) @(negedge sys_clk);
    chk(8'(expq.size()), 8'h00, "missing answers");
    close_out();
  end
endmodule
